// *** hw/lms_pkg.sv ***
// Constants and carrier types for the LED multiplex serial port block
package lms_pkg;

  localparam int          WORD_BITS      = 16;
  localparam int          NUM_LINES      = 9;
  localparam int          MAX_DIGITS     = 8;
  localparam int          DIGIT_BITS     = 3;
  localparam int          LINE_BITS      = 4;

  // Command addresses, upper byte of the word
  localparam logic [7:0]  CMD_NOP        = 8'h00;
  localparam logic [7:0]  CMD_SCAN_LIMIT = 8'h03;
  localparam logic [7:0]  CMD_PAGE_MASK  = 8'hf8;
  localparam logic [7:0]  CMD_P0_PAGE    = 8'h20;
  localparam logic [7:0]  CMD_P1_PAGE    = 8'h40;
  localparam logic [7:0]  CMD_BOTH_PAGE  = 8'h60;

  // Scan five digits (0..4) after reset
  localparam logic [2:0]  SCAN_LIMIT_RST = 3'h4;
  localparam logic [7:0]  DIGIT_RST      = 8'h00;
  // Data bit that carries the decimal point
  localparam logic [2:0]  SEG_DP_BIT     = 3'h7;

  // Internal multiplex oscillator stand-in
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          INT_OSC_PERIOD_NS = 250;
  localparam int          INT_OSC_DIV    =
    (INT_OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TICKS_PER_DIGIT = 16;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } lms_cmd_s;

  typedef struct packed {
    logic [NUM_LINES-1:0] level;
    logic [NUM_LINES-1:0] oe;
  } lms_drive_s;

  typedef enum logic [1:0] {
    ST_BLANK = 2'b01,
    ST_SHOW  = 2'b10
  } lms_scan_e;

endpackage : lms_pkg

// *** hw/lms_serial_rx.sv ***
// Serial command receiver: pin synchronisers, shift register and word latch
`timescale 1ns/1ps
module lms_serial_rx
  import lms_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     rst_n_i,
  input  wire logic     sclk_i,
  input  wire logic     cs_n_i,
  input  wire logic     din_i,
  output lms_pkg::lms_cmd_s word_o,
  output logic          strobe_o
);
  import lms_pkg::*;

  logic                 sclk_meta_r;
  logic                 sclk_sync_r;
  logic                 sclk_prev_r;
  logic                 cs_meta_r;
  logic                 cs_sync_r;
  logic                 cs_prev_r;
  logic                 din_meta_r;
  logic                 din_sync_r;
  logic [WORD_BITS-1:0] shift_r;
  logic [WORD_BITS-1:0] shift_nxt;
  wire                  sclk_rise;
  wire                  cs_rise;
  wire                  shift_en;

  // Edges come from the second stage only; first stage feeds nothing else
  assign sclk_rise = sclk_sync_r & ~sclk_prev_r;
  assign cs_rise   = cs_sync_r & ~cs_prev_r;
  assign shift_en  = sclk_rise & ~cs_sync_r;
  assign shift_nxt = {shift_r[WORD_BITS-2:0], din_sync_r};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_meta_r <= 1'b0;
      sclk_sync_r <= 1'b0;
      sclk_prev_r <= 1'b0;
      cs_meta_r   <= 1'b1;
      cs_sync_r   <= 1'b1;
      cs_prev_r   <= 1'b1;
      din_meta_r  <= 1'b0;
      din_sync_r  <= 1'b0;
    end else begin
      sclk_meta_r <= sclk_i;
      sclk_sync_r <= sclk_meta_r;
      sclk_prev_r <= sclk_sync_r;
      cs_meta_r   <= cs_n_i;
      cs_sync_r   <= cs_meta_r;
      cs_prev_r   <= cs_sync_r;
      din_meta_r  <= din_i;
      din_sync_r  <= din_meta_r;
    end
  end

  // Never cleared, so short or long frames keep the last 16 bits
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_r <= '0;
    end else if (shift_en) begin
      shift_r <= shift_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_o   <= '0;
      strobe_o <= 1'b0;
    end else begin
      strobe_o <= cs_rise;
      if (cs_rise) begin
        word_o <= shift_r;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_shift_on_edge: assert property (
    shift_en |=> shift_r == {$past(shift_r[WORD_BITS-2:0]), $past(din_sync_r)})
    else $error("Shift register missed a serial clock edge");

  a_hold_deselected: assert property (
    cs_sync_r |=> $stable(shift_r))
    else $error("Shift register moved while deselected");

  a_capture_on_rise: assert property (
    cs_rise |=> strobe_o && (word_o == $past(shift_r)))
    else $error("Word not latched on select rise");

  a_strobe_single: assert property (
    strobe_o |=> !strobe_o)
    else $error("Command strobe longer than one cycle");

endmodule : lms_serial_rx

// *** hw/lms_top.sv ***
// LED multiplex driver: serial command port, digit planes and line scanner
`timescale 1ns/1ps

module lms_top
  import lms_pkg::*;
#(
  parameter int NUM_DIGITS      = lms_pkg::MAX_DIGITS,
  parameter int OSC_DIV         = lms_pkg::INT_OSC_DIV,
  parameter int TICKS_PER_DIGIT = lms_pkg::TICKS_PER_DIGIT
) (
  input  wire logic                         REF_CLK_I,
  input  wire logic                         RST_N_I,
  input  wire logic                         SCLK_I,
  input  wire logic                         CS_N_I,
  input  wire logic                         DIN_I,
  input  wire logic                         MUX_CLOCK_PIN_I,
  input  wire logic                         MUX_EXT_SEL_I,
  output logic [lms_pkg::NUM_LINES-1:0]     DRIVE_LINE_O,
  output logic [lms_pkg::NUM_LINES-1:0]     DRIVE_LINE_OE_O,
  output logic [lms_pkg::DIGIT_BITS-1:0]    SCAN_DIGIT_O,
  output lms_pkg::lms_cmd_s                 CMD_WORD_O,
  output logic                              CMD_STROBE_O
);
  import lms_pkg::*;

  localparam int  CNT_BITS  = 16;
  localparam logic [CNT_BITS-1:0] OSC_LAST  = CNT_BITS'(OSC_DIV - 1);
  localparam logic [CNT_BITS-1:0] TICK_LAST = CNT_BITS'(TICKS_PER_DIGIT - 1);

  // Segment data bit for line 'line' while digit 'k' is scanned
  function automatic logic [2:0] seg_sel(input logic [LINE_BITS-1:0] line,
                                         input logic [DIGIT_BITS-1:0] k);
    logic [LINE_BITS-1:0] pos;
    pos = (line < {1'b0, k}) ? line : line - 4'h1;
    seg_sel = (pos == 4'h0) ? SEG_DP_BIT : pos[2:0] - 3'h1;
  endfunction : seg_sel

  // Serial command path
  lms_cmd_s             cmd_word;
  logic                 cmd_strobe;

  lms_serial_rx u_rx (
    .clk_i    (REF_CLK_I),
    .rst_n_i  (RST_N_I),
    .sclk_i   (SCLK_I),
    .cs_n_i   (CS_N_I),
    .din_i    (DIN_I),
    .word_o   (cmd_word),
    .strobe_o (cmd_strobe)
  );

  // No read path exists: the port only ever accepts words
  assign CMD_WORD_O   = cmd_word;
  assign CMD_STROBE_O = cmd_strobe;

  // Command decode
  wire [7:0]            cmd_page;
  wire [DIGIT_BITS-1:0] cmd_idx;
  wire                  hit_p0;
  wire                  hit_p1;
  wire                  hit_scan;

  assign cmd_page = cmd_word.addr & CMD_PAGE_MASK;
  assign cmd_idx  = cmd_word.addr[DIGIT_BITS-1:0];
  assign hit_p0   = cmd_strobe &
                    ((cmd_page == CMD_P0_PAGE) | (cmd_page == CMD_BOTH_PAGE));
  assign hit_p1   = cmd_strobe &
                    ((cmd_page == CMD_P1_PAGE) | (cmd_page == CMD_BOTH_PAGE));
  assign hit_scan = cmd_strobe & (cmd_word.addr == CMD_SCAN_LIMIT);

  // Digit planes; plane one is stored but has no output and is read only by the checks below
  logic [7:0]            plane0_r [MAX_DIGITS];
  logic [7:0]            plane1_r [MAX_DIGITS];
  logic [DIGIT_BITS-1:0] scan_limit_r;

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < MAX_DIGITS; i++) begin
        plane0_r[i] <= DIGIT_RST;
        plane1_r[i] <= DIGIT_RST;
      end
    end else begin
      if (hit_p0) begin
        plane0_r[cmd_idx] <= cmd_word.data;
      end
      if (hit_p1) begin
        plane1_r[cmd_idx] <= cmd_word.data;
      end
    end
  end

  // Eight is always legal, even when fewer cathodes exist
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scan_limit_r <= SCAN_LIMIT_RST;
    end else if (hit_scan) begin
      scan_limit_r <= cmd_word.data[DIGIT_BITS-1:0];
    end
  end

  // Multiplex clock: external pin is asynchronous, so synchronise it
  logic                 mux_meta_r;
  logic                 mux_sync_r;
  logic                 mux_prev_r;
  logic                 sel_meta_r;
  logic                 sel_sync_r;
  logic [CNT_BITS-1:0]  osc_cnt_r;
  wire                  ext_tick;
  wire                  int_tick;
  wire                  mux_tick;

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mux_meta_r <= 1'b0;
      mux_sync_r <= 1'b0;
      mux_prev_r <= 1'b0;
      sel_meta_r <= 1'b0;
      sel_sync_r <= 1'b0;
    end else begin
      mux_meta_r <= MUX_CLOCK_PIN_I;
      mux_sync_r <= mux_meta_r;
      mux_prev_r <= mux_sync_r;
      sel_meta_r <= MUX_EXT_SEL_I;
      sel_sync_r <= sel_meta_r;
    end
  end

  // 8 MHz external clock still gives 12 samples per period at 100 MHz
  assign ext_tick = mux_sync_r & ~mux_prev_r;
  assign int_tick = (osc_cnt_r == OSC_LAST);
  assign mux_tick = sel_sync_r ? ext_tick : int_tick;

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      osc_cnt_r <= '0;
    end else begin
      osc_cnt_r <= int_tick ? '0 : osc_cnt_r + 16'h0001;
    end
  end

  // Scan sequencer: a blank tick between digits avoids ghosting
  lms_scan_e             state_r;
  lms_scan_e             state_nxt;
  logic [CNT_BITS-1:0]   tick_cnt_r;
  logic [DIGIT_BITS-1:0] cur_digit_r;
  wire                   dwell_done;
  wire                   step;
  wire                   digit_present;
  wire [DIGIT_BITS-1:0]  digit_nxt;

  assign dwell_done    = (tick_cnt_r == TICK_LAST);
  assign step          = (state_r == ST_SHOW) & mux_tick & dwell_done;
  assign digit_nxt     = (cur_digit_r >= scan_limit_r) ? '0
                       : cur_digit_r + 3'h1;
  assign digit_present = (32'(cur_digit_r) < NUM_DIGITS);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_BLANK: begin
        if (mux_tick) begin
          state_nxt = ST_SHOW;
        end
      end
      ST_SHOW: begin
        if (step) begin
          state_nxt = ST_BLANK;
        end
      end
      default: state_nxt = ST_BLANK;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r     <= ST_BLANK;
      tick_cnt_r  <= '0;
      cur_digit_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_BLANK) begin
        tick_cnt_r <= '0;
      end else if (mux_tick) begin
        tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
      if (step) begin
        cur_digit_r <= digit_nxt;
      end
    end
  end

  // Line pattern for the digit being scanned
  lms_drive_s           drive_nxt;
  wire                  showing;
  wire [7:0]            cur_data;

  assign showing  = (state_r == ST_SHOW) & digit_present;
  assign cur_data = plane0_r[cur_digit_r];

  for (genvar j = 0; j < NUM_LINES; j++) begin : g_line
    wire is_cc;
    wire seg_on;
    assign is_cc  = (LINE_BITS'(j) == {1'b0, cur_digit_r});
    assign seg_on = cur_data[seg_sel(LINE_BITS'(j), cur_digit_r)];
    assign drive_nxt.level[j] = ~is_cc;
    assign drive_nxt.oe[j]    = showing & (is_cc | seg_on);
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      DRIVE_LINE_O    <= '0;
      DRIVE_LINE_OE_O <= '0;
      SCAN_DIGIT_O    <= '0;
    end else begin
      DRIVE_LINE_O    <= drive_nxt.level;
      DRIVE_LINE_OE_O <= drive_nxt.oe;
      SCAN_DIGIT_O    <= cur_digit_r;
    end
  end

  // Helpers for the checks below
  wire [7:0] p0_at_idx;
  wire [7:0] p1_at_idx;
  wire       p0_only;
  wire       dp_line_on;
  wire [LINE_BITS-1:0] dp_line;

  assign p0_at_idx  = plane0_r[cmd_idx];
  assign p1_at_idx  = plane1_r[cmd_idx];
  assign p0_only    = cmd_strobe & (cmd_page == CMD_P0_PAGE);
  assign dp_line    = (cur_digit_r == 3'h0) ? 4'h1 : 4'h0;
  assign dp_line_on = showing & cur_data[SEG_DP_BIT];

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  a_cathode_sink: assert property (
    showing |=> DRIVE_LINE_OE_O[$past(cur_digit_r)] && !DRIVE_LINE_O[$past(cur_digit_r)])
    else $error("Scanned digit line is not sinking");

  a_blank_high_z: assert property (
    (state_r == ST_BLANK) |=> (DRIVE_LINE_OE_O == '0))
    else $error("Lines driven during blank interval");

  a_missing_dark: assert property (
    !digit_present |=> (DRIVE_LINE_OE_O == '0))
    else $error("Absent digit position drives lines");

  a_dp_source: assert property (
    dp_line_on |=> DRIVE_LINE_OE_O[$past(dp_line)] && DRIVE_LINE_O[$past(dp_line)])
    else $error("Decimal point not sourced on first free line");

  a_plane_write: assert property (
    hit_p0 |=> (p0_at_idx == $past(cmd_word.data)))
    else $error("Plane zero write lost");

  a_plane1_kept: assert property (
    p0_only |=> (p1_at_idx == $past(p1_at_idx)))
    else $error("Plane one altered by plane zero command");

  a_scan_wrap: assert property (
    (step && (cur_digit_r >= scan_limit_r)) |=> (cur_digit_r == 3'h0))
    else $error("Scan did not wrap at limit");

endmodule : lms_top

// *** tb/lms_host_model.sv ***
// Host-side model writing serial command words into the block
`timescale 1ns/1ps
module lms_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  localparam realtime HALF = 62.5;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end

  // Sends bits[n-1:0], first bit highest
  task automatic send(input logic [31:0] bits, input int n, input logic idle_hi);
    #1.5;
    sclk_o = idle_hi;
    #HALF;
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b0;
      din_o  = bits[i];
      #HALF;
      sclk_o = 1'b1;
      #HALF;
    end
    sclk_o = idle_hi;
    #HALF;
    cs_n_o = 1'b1;
    // Released line must not keep showing the last bit
    din_o  = ~din_o;
    #(2 * HALF);
  endtask : send

  // Clock and data activity meant for another peripheral
  task automatic noise(input int n);
    #1.5;
    for (int i = 0; i < n; i++) begin
      sclk_o = ~sclk_o;
      din_o  = ~din_o;
      #HALF;
    end
  endtask : noise
endmodule : lms_host_model

// *** tb/lms_top_tb.sv ***
// Self-checking bench for the LED multiplex serial port block
`timescale 1ns/1ps
module lms_top_tb;
  import lms_pkg::*;
  logic                  ref_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  mux_pin = 1'b0;
  logic                  ext_sel = 1'b0;
  logic                  sclk, cs_n, din;
  logic [NUM_LINES-1:0]  line8, oe8, line5, oe5;
  logic [DIGIT_BITS-1:0] dig8, dig5;
  lms_cmd_s              word8, word5;
  logic                  strobe8, strobe5;
  int                    strobes5 = 0;
  int                    failures = 0;
  int                    samples_checked = 0;
  int                    strobes = 0;
  logic [15:0]           last_word;

  always #5 ref_clk = ~ref_clk;
  // External mux clock at 4 MHz, off the system clock edges
  initial begin
    #2;
    forever #125 mux_pin = ~mux_pin;
  end
  always @(negedge ref_clk) if (strobe8 === 1'b1) strobes++;
  always @(negedge ref_clk) if (strobe5 === 1'b1) strobes5++;

  lms_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));

  lms_top #(.OSC_DIV(2), .TICKS_PER_DIGIT(2)) DUT (
    .REF_CLK_I(ref_clk), .RST_N_I(rst_n), .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din),
    .MUX_CLOCK_PIN_I(mux_pin), .MUX_EXT_SEL_I(ext_sel), .DRIVE_LINE_O(line8),
    .DRIVE_LINE_OE_O(oe8), .SCAN_DIGIT_O(dig8), .CMD_WORD_O(word8), .CMD_STROBE_O(strobe8));

  lms_top #(.NUM_DIGITS(5), .OSC_DIV(2), .TICKS_PER_DIGIT(2)) DUT5 (
    .REF_CLK_I(ref_clk), .RST_N_I(rst_n), .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din),
    .MUX_CLOCK_PIN_I(mux_pin), .MUX_EXT_SEL_I(ext_sel), .DRIVE_LINE_O(line5),
    .DRIVE_LINE_OE_O(oe5), .SCAN_DIGIT_O(dig5), .CMD_WORD_O(word5), .CMD_STROBE_O(strobe5));

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cycles

  task automatic put(input logic [15:0] w);
    host.send({16'h0000, w}, 16, 1'b0);
    cycles(8);
  endtask : put

  task automatic t_write(input logic [15:0] w, input logic idle_hi);
    int s0;
    s0 = strobes;
    host.send({16'h0000, w}, 16, idle_hi);
    cycles(8);
    chk("strobe count", 16'(strobes - s0), 16'h0001);
    chk("latched word", word8, w);
    last_word = w;
    $display("test write %h idle %0d done", w, idle_hi);
  endtask : t_write

  task automatic t_partial();
    host.noise(7);
    cycles(4);
    host.send({24'h000000, 8'ha5}, 8, 1'b0);
    cycles(8);
    chk("short frame", word8, {last_word[7:0], 8'ha5});
    host.send(32'h000f1234, 20, 1'b1);
    cycles(8);
    chk("long frame", word8, 16'h1234);
    $display("test odd frames done");
  endtask : t_partial

  task automatic t_scan(input int k, input logic [7:0] data, input int bound);
    logic [NUM_LINES-1:0] exp_oe;
    int i;
    int n;
    n = 0;
    while (!(dig8 === 3'(k) && oe8[k] === 1'b1)) begin
      if (n == bound) begin
        failures++;
        $display("MISMATCH t=%0t digit %0d never shown", $time, k);
        final_report();
      end
      n++;
      cycles(1);
    end
    exp_oe = '0;
    exp_oe[k] = 1'b1;
    i = 0;
    for (int j = 0; j < NUM_LINES; j++) begin
      if (j != k) begin
        // Source order dp first, then a up to g
        exp_oe[j] = data[(i == 0) ? 7 : i - 1];
        i++;
      end
    end
    chk("line enables", 16'(oe8), 16'(exp_oe));
    chk("line levels", 16'(line8 & oe8), 16'(exp_oe & ~(9'h001 << k)));
    $display("test scan digit %0d done", k);
  endtask : t_scan

  task automatic t_five();
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 2000; n++) begin
      cycles(1);
      if (dig5 === 3'h7) seen = 1'b1;
      if (dig5 === 3'h5 || dig5 === 3'h6 || dig5 === 3'h7) begin
        chk("missing digit enables", 16'(oe5), 16'h0000);
      end else begin
        // Present positions behave exactly as on the eight-digit part
        chk("present digit enables", 16'(oe5), 16'(oe8));
        chk("present digit levels", 16'(line5 & oe5), 16'(line8 & oe8));
      end
    end
    chk("five-digit scans eight", 16'(seen), 16'h0001);
    chk("five-digit word", word5, {CMD_P0_PAGE, 8'hff});
    chk("five-digit strobes", 16'(strobes5), 16'h0009);
    $display("test five-digit variant done");
  endtask : t_five

  // Entered at the first shown cycle of digit 7 on the external clock
  task automatic t_ext_dwell();
    int n;
    n = 0;
    while (dig8 === 3'h7 && n < 200) begin
      n++;
      cycles(1);
    end
    // Two shown ticks of a 250 ns external clock is 50 cycles; internal would be ~4
    chk("external dwell", 16'(n >= 45 && n <= 55), 16'h0001);
    $display("test external mux clock done");
  endtask : t_ext_dwell

  initial begin
    last_word = 16'h0000;
    cycles(10);
    rst_n = 1'b1;
    // Scanner starts driving digit 0 three edges after release
    cycles(1);
    chk("reset enables", 16'(oe8), 16'h0000);
    chk("reset word", word8, 16'h0000);
    chk("reset digit", 16'(dig8), 16'h0000);
    $display("test reset done");
    t_write(16'h5a3c, 1'b0);
    t_write(16'hc381, 1'b1);
    t_partial();
    put({CMD_SCAN_LIMIT, 8'h07});
    put({CMD_P0_PAGE | 8'h03, 8'h81});
    t_scan(3, 8'h81, 400);
    // Plane one only: shown pattern must not change
    put({CMD_P1_PAGE | 8'h03, 8'h7e});
    t_scan(3, 8'h81, 400);
    put({CMD_BOTH_PAGE | 8'h07, 8'h55});
    t_scan(7, 8'h55, 400);
    put({CMD_P0_PAGE, 8'hff});
    t_scan(0, 8'hff, 400);
    ext_sel = 1'b1;
    cycles(10);
    t_scan(7, 8'h55, 2000);
    t_ext_dwell();
    t_five();
    final_report();
  end
endmodule : lms_top_tb
